// ===== spw_core.sv
// spw_core: display timing core of a 16-channel constant-current sink
// driver: 193-bit common shift register, grayscale and control latches,
// spread pwm segment scheduling, auto repeat, auto refresh, timing reset.
// assumes: shift clock, serial data, load strobe and grayscale clock are
// asynchronous pins well below mclk_i/3; a classic wishbone master.
//
// Behaviour
// - grayscale 32 gives one clock on-time in each of 32 segments.
// - grayscale 33 gives two clocks in segment 1, one elsewhere.
// - each increment adds a clock to the next segment in bit-reversed order.
// - grayscale 4064 gives 127 clocks in every segment.
// - grayscale 4095 gives 128 clocks in segments 1-31, 127 in segment 32.
// - with auto repeat set, the display period restarts forever.
// - without auto repeat, run one period after blank fall or timing reset.
// - with auto repeat, the 4096th clock restarts display like a blank pulse.
// - new data waits in first latch, copied to second at 4096th clock.
// - setting blank before period end copies first latch to second at once.
// - load while blank is set writes first and second latch together.
// - function control bits 119-122 act as soon as first latch is written.
// - timing-reset load clears the grayscale counter and blanks outputs.
// - timing-reset load writes shift data to both grayscale latches.
// - timing-reset load copies brightness from first to second latch.
// - after timing reset counting resumes at next grayscale clock edge.
// - without timing reset a grayscale load neither clears counter nor blanks outputs.
// - shift register top bit picks grayscale (0) or control (1) latch.
// - control latches hold 137 and 119 bits, grayscale latches 192.
// - shift clock moves input into lsb, msb drives serial output.
// - display period is 32 segments of 128 grayscale clocks each.
// - while blank is set outputs are off, counter zero, timing idle.

`timescale 1ns/1ps

module spw_core
(
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  resetn_i,
  // serial link pins
  input  wire logic                  shift_clock_i,
  input  wire logic                  serial_data_input_i,
  input  wire logic                  load_strobe_i,
  input  wire logic                  grayscale_clock_i,
  output logic                       serial_data_output_o,
  // channel and brightness outputs
  output logic [spw_pkg::CH_N-1:0]   current_sink_channel_o,
  output logic [spw_pkg::BC_W-1:0]   global_brightness_o,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // order: shift clock, data, load strobe, grayscale clock
  logic [3:0] pin_m_q;
  logic [3:0] pin_s_q;
  logic [3:0] pin_d_q;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_m_q <= 4'h0;
      pin_s_q <= 4'h0;
      pin_d_q <= 4'h0;
    end
    else
    begin
      pin_m_q <= {grayscale_clock_i, load_strobe_i,
                  serial_data_input_i, shift_clock_i};
      pin_s_q <= pin_m_q;
      pin_d_q <= pin_s_q;
    end
  end

  wire logic sclk_rise = pin_s_q[0] & ~pin_d_q[0];
  wire logic sin_bit   = pin_s_q[1];
  wire logic lat_rise  = pin_s_q[2] & ~pin_d_q[2];
  wire logic gclk_rise = pin_s_q[3] & ~pin_d_q[3];

  // ----------------------------------------------------------------
  // shift register and latches
  // ----------------------------------------------------------------
  logic [spw_pkg::SR_W-1:0]  sr_q;
  logic [spw_pkg::GS_W-1:0]  gs1_q;
  logic [spw_pkg::GS_W-1:0]  gs2_q;
  logic [spw_pkg::CL1_W-1:0] cl1_q;
  logic [spw_pkg::CL2_W-1:0] cl2_q;

  // timing state
  logic [11:0] cnt_q;
  logic        run_q;
  logic [spw_pkg::CH_N-1:0] out_q;
  logic        oe_q;

  wire spw_pkg::spw_fc_t fc = '{
    spread_pwm_select:   cl1_q[spw_pkg::FC_SPREAD],
    timing_reset_enable: cl1_q[spw_pkg::FC_TIMING_RESET_ENABLE],
    auto_repeat_enable:  cl1_q[spw_pkg::FC_REPEAT],
    blank:               cl1_q[spw_pkg::FC_BLANK]
  };

  // load decode: top bit chooses destination
  wire logic ld_gs   = lat_rise & ~sr_q[spw_pkg::SR_MSB];
  wire logic ld_ctl  = lat_rise &  sr_q[spw_pkg::SR_MSB];
  wire logic new_blk = sr_q[spw_pkg::FC_BLANK];
  // timing reset only on a grayscale write with the enable set
  wire logic tmg_rst = ld_gs & fc.timing_reset_enable;
  // blank rising by a control write uploads first latch at once
  wire logic blk_set = ld_ctl & new_blk & ~fc.blank;
  wire logic blk_clr = ld_ctl & ~new_blk & fc.blank;
  wire logic blk_now = ld_ctl ? new_blk : fc.blank;
  // end of period: the 4096th grayscale clock
  wire logic last_clk = gclk_rise & run_q & (cnt_q == spw_pkg::GS_LAST);

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sr_q <= '0;
    else if (sclk_rise)
      sr_q <= {sr_q[spw_pkg::SR_W-2:0], sin_bit};
  end

  // grayscale latches
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gs1_q <= '0;
      gs2_q <= '0;
    end
    else
    begin
      if (ld_gs)
        gs1_q <= sr_q[spw_pkg::GS_W-1:0];
      if (ld_gs && (fc.blank || fc.timing_reset_enable))
        gs2_q <= sr_q[spw_pkg::GS_W-1:0];
      else if (last_clk || blk_set)
        gs2_q <= gs1_q;
    end
  end

  // control latches; blank comes up set so outputs stay dark until written
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cl1_q                    <= '0;
      cl1_q[spw_pkg::FC_BLANK] <= 1'b1;
      cl2_q                    <= '0;
    end
    else
    begin
      if (ld_ctl)
        cl1_q <= sr_q[spw_pkg::CL1_W-1:0];
      if (ld_ctl && (fc.blank || new_blk))
        cl2_q <= sr_q[spw_pkg::CL2_W-1:0];
      else if (tmg_rst || last_clk)
        cl2_q <= cl1_q[spw_pkg::CL2_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // spread pwm decision per channel
  // ----------------------------------------------------------------
  // segment index and position inside it for the slot shown at the next grayscale edge
  wire logic [spw_pkg::SEG_W-1:0] seg = cnt_q[11:7];
  wire logic [spw_pkg::POS_W-1:0] pos = cnt_q[6:0];
  // segment rank in the spreading order is the bit-reversed index
  wire logic [spw_pkg::SEG_W-1:0] rank = {seg[0], seg[1], seg[2],
                                          seg[3], seg[4]};
  logic [spw_pkg::CH_N-1:0] on_slot;

  genvar ch;
  generate
    for (ch = 0; ch < spw_pkg::CH_N; ch++)
    begin : g_ch
      wire logic [11:0] gv = gs2_q[ch*spw_pkg::GSV_W +: spw_pkg::GSV_W];
      // extra clock for the first (value mod 32) ranks
      wire logic        ext = (rank < gv[4:0]);
      wire logic [7:0]  ton = {1'b0, gv[11:5]} + {7'h00, ext};
      // on from segment start for ton clocks: covers 32,33,4064,4095
      assign on_slot[ch] = ({1'b0, pos} < ton);
    end
  endgenerate

  // ----------------------------------------------------------------
  // display timing controller
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      out_q <= '0;
    end
    else if (blk_now)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      out_q <= '0;
    end
    else if (tmg_rst || blk_clr)
    begin
      // next grayscale edge shows slot zero
      cnt_q <= '0;
      run_q <= 1'b1;
      out_q <= '0;
    end
    else if (gclk_rise)
    begin
      if (run_q)
      begin
        out_q <= on_slot;
        cnt_q <= cnt_q + 12'h001;
        if (cnt_q == spw_pkg::GS_LAST)
          run_q <= fc.auto_repeat_enable;
      end
      else
        out_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: ctrl (output enable) and status
  // ----------------------------------------------------------------
  logic [31:0] rd_q;
  logic        ack_q;

  wire logic        req     = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic        hit_ctl = (wb_adr_i == spw_pkg::ADR_CTRL);
  wire logic        hit_st  = (wb_adr_i == spw_pkg::ADR_STATUS);
  // a write lands at the edge where the master samples ack, not when taken
  wire logic        wr_ctl  = ack_q & wb_cyc_i & wb_stb_i & wb_we_i & hit_ctl & wb_sel_i[0];
  wire logic [31:0] st_word = {11'h000,
                               fc.spread_pwm_select,
                               fc.timing_reset_enable,
                               fc.auto_repeat_enable,
                               fc.blank,
                               run_q,
                               4'h0,
                               cnt_q};
  wire logic [31:0] rd_mux  = hit_ctl ? {31'h0000_0000, oe_q} :
                              hit_st  ? st_word : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ack_q <= 1'b0;
      rd_q  <= '0;
      oe_q  <= spw_pkg::CTRL_RST[spw_pkg::CTRL_OE];
    end
    else
    begin
      ack_q <= req;
      if (req)
        rd_q <= rd_mux;
      if (wr_ctl)
        oe_q <= wb_dat_i[spw_pkg::CTRL_OE];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // output enable is a software gate only; timing keeps running under it
  assign current_sink_channel_o = out_q & {spw_pkg::CH_N{oe_q}};
  assign global_brightness_o    = cl2_q[spw_pkg::BC_LSB +: spw_pkg::BC_W];
  assign serial_data_output_o   = sr_q[spw_pkg::SR_MSB];
  assign wb_dat_o               = rd_q;
  assign wb_ack_o               = ack_q;

endmodule : spw_core

// ===== spw_pkg.sv
// spw_pkg: constants and types for the spread pwm display timing core.
// assumes nothing of its surroundings; imported by scoped name only.
package spw_pkg;

  // ----------------------------------------------------------------
  // shift register and latch geometry
  // ----------------------------------------------------------------
  localparam int SR_W     = 193;
  localparam int SR_MSB   = 192;
  localparam int GS_W     = 192;
  localparam int CL1_W    = 137;
  localparam int CL2_W    = 119;
  localparam int CH_N     = 16;
  localparam int GSV_W    = 12;
  localparam int BC_LSB   = 112;
  localparam int BC_W     = 7;

  // ----------------------------------------------------------------
  // function control positions in the first control latch
  // ----------------------------------------------------------------
  localparam int FC_BLANK  = 119;
  localparam int FC_REPEAT = 120;
  localparam int FC_TIMING_RESET_ENABLE = 121;
  localparam int FC_SPREAD = 122;

  // ----------------------------------------------------------------
  // display timing
  // ----------------------------------------------------------------
  localparam logic [11:0] GS_LAST  = 12'hf_ff;
  localparam int          SEG_W    = 5;
  localparam int          POS_W    = 7;

  // ----------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL   = 8'h00;
  localparam logic [7:0]  ADR_STATUS = 8'h04;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam int          CTRL_OE    = 0;
  localparam int          ST_RUN     = 16;
  localparam int          ST_BLANK   = 17;
  localparam int          ST_REPEAT  = 18;
  localparam int          ST_TIMING_RESET_ENABLE  = 19;
  localparam int          ST_SPREAD  = 20;

  // decoded function control bits
  typedef struct packed {
    logic spread_pwm_select;
    logic timing_reset_enable;
    logic auto_repeat_enable;
    logic blank;
  } spw_fc_t;

endpackage : spw_pkg

// ===== spw_core_checker.sv
// spw_core_checker: port level assertions for spw_core.
// assumes: link pins are asynchronous to mclk_i and low at reset release.
`timescale 1ns/1ps
module spw_core_checker
(
  // clock and reset
  input wire logic                    mclk_i,
  input wire logic                    resetn_i,
  // link pins
  input wire logic                    shift_clock_i,
  input wire logic                    serial_data_input_i,
  input wire logic                    load_strobe_i,
  input wire logic                    grayscale_clock_i,
  input wire logic                    serial_data_output_o,
  // outputs and bus
  input wire logic [spw_pkg::CH_N-1:0] current_sink_channel_o,
  input wire logic [spw_pkg::BC_W-1:0] global_brightness_o,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_ack_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  logic [1:0]   gs_q, sc_q, lt_q;
  logic [3:0]   ga_q, sa_q, la_q;
  logic [192:0] sr_q;
  wire logic    gs_rise = gs_q[0] & ~gs_q[1];
  wire logic    sc_rise = sc_q[0] & ~sc_q[1];
  wire logic    lt_rise = lt_q[0] & ~lt_q[1];
  logic         ack_d_q;
  wire logic    ack_near;
  // ack of this or the previous cycle; registered so no sampled-value call sits in an assign
  assign ack_near = wb_ack_o | ack_d_q;

  // ages since each pin edge saturate so they never wrap into a false match
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      {gs_q, sc_q, lt_q, ga_q, sa_q, la_q} <= '0;
      sr_q <= '0;
      ack_d_q <= 1'b0;
    end
    else
    begin
      {gs_q, sc_q, lt_q} <= {gs_q[0], grayscale_clock_i, sc_q[0], shift_clock_i,
                             lt_q[0], load_strobe_i};
      ga_q <= gs_rise ? 4'h0 : ga_q + {3'h0, ga_q != 4'hf};
      sa_q <= sc_rise ? 4'h0 : sa_q + {3'h0, sa_q != 4'hf};
      la_q <= lt_rise ? 4'h0 : la_q + {3'h0, la_q != 4'hf};
      sr_q <= sc_rise ? {sr_q[191:0], serial_data_input_i} : sr_q;
      ack_d_q <= wb_ack_o;
    end

  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_serial_data_output_follows_msb: assert property (
    sc_rise |-> ##[1:6] serial_data_output_o == sr_q[192])
    else $error("serial out not the shifted msb");
  a_serial_data_output_only_shift: assert property (
    $changed(serial_data_output_o) |-> sc_rise || sa_q <= 4'h6)
    else $error("serial out moved without shift");
  a_chan_on_tick: assert property (
    |(current_sink_channel_o & ~$past(current_sink_channel_o)) |->
      gs_rise || ga_q <= 4'h8 || ack_near || $past(wb_ack_o, 2))
    else $error("channel on away from grayscale tick");
  a_chan_off_cause: assert property (
    |(~current_sink_channel_o & $past(current_sink_channel_o)) |->
      gs_rise || ga_q <= 4'h8 || lt_rise || la_q <= 4'h8 || ack_near)
    else $error("channel off without cause");
  a_bc_copy_moment: assert property (
    $changed(global_brightness_o) |-> gs_rise || ga_q <= 4'h8 || lt_rise || la_q <= 4'h8)
    else $error("brightness changed outside a copy");

  c_chan_on: cover property (gs_rise ##[1:8] (|current_sink_channel_o));
  c_serial_data_output_move: cover property (sc_rise ##[1:6] $changed(serial_data_output_o));
  c_bus: cover property (wb_cyc_i && wb_stb_i ##1 wb_ack_o);
endmodule : spw_core_checker

bind spw_core spw_core_checker spw_core_checker_inst (.*);

// ===== spw_host.sv
// spw_host: host controller model driving the link pins of spw_core.
// assumes: pins change only just after a rising edge of mclk_i.
`timescale 1ns/1ps
module spw_host
(
  // clock and control
  input  wire logic mclk_i,
  input  wire logic gs_en_i,
  // link pins
  output logic      shift_clock_o,
  output logic      serial_data_input_o,
  output logic      load_strobe_o,
  output logic      grayscale_clock_o
);
  logic [2:0] gs_cnt_q;

  initial
  begin
    {shift_clock_o, serial_data_input_o, load_strobe_o} = 3'h0;
    {grayscale_clock_o, gs_cnt_q} = 4'h0;
  end

  // 48 ns clock; a high phase is finished, then the clock stands low
  always @(posedge mclk_i)
  begin
    if (gs_en_i || grayscale_clock_o)
    begin
      gs_cnt_q <= (gs_cnt_q == 3'h5) ? 3'h0 : gs_cnt_q + 3'h1;
      if (gs_cnt_q == 3'h5)
        grayscale_clock_o <= ~grayscale_clock_o;
    end
  end

  // msb first, data moves only while the shift clock is low
  task automatic send_word(input logic [192:0] w);
    for (int i = 192; i >= 0; i--)
    begin
      @(posedge mclk_i);
      serial_data_input_o <= w[i];
      shift_clock_o       <= 1'b0;
      repeat (4) @(posedge mclk_i);
      shift_clock_o <= 1'b1;
      repeat (3) @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
    shift_clock_o       <= 1'b0;
    serial_data_input_o <= ~w[0];
    repeat (4) @(posedge mclk_i);
    load_strobe_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    load_strobe_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask : send_word
endmodule : spw_host

// ===== tb.sv
// tb: self-checking bench for spw_core driven by the spw_host model.
// assumes: spw_pkg, spw_core, spw_host and the checker compiled first.
`timescale 1ns/1ps
module tb;
  logic        mclk_i, resetn_i, gs_en, sclk, sdin, lat, grayscale_clock, serial_data_output;
  logic        wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0]  wb_sel, sel_req;
  logic [15:0] chan;
  logic [6:0]  bc;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [11:0] gs1 [16], gs2 [16], gs3 [16];
  int          n_fail, n_checks;

  spw_core spw_core_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .shift_clock_i(sclk),
    .serial_data_input_i(sdin), .load_strobe_i(lat), .grayscale_clock_i(grayscale_clock),
    .serial_data_output_o(serial_data_output), .current_sink_channel_o(chan), .global_brightness_o(bc),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  spw_host spw_host_inst (.mclk_i(mclk_i), .gs_en_i(gs_en), .shift_clock_o(sclk),
    .serial_data_input_o(sdin), .load_strobe_o(lat), .grayscale_clock_o(grayscale_clock));

  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge mclk_i);
    {wb_cyc, wb_stb, wb_we} <= {2'h3, we};
    wb_adr  <= adr;
    wb_sel  <= sel_req;
    wb_wdat <= dat;
    do @(posedge mclk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    {wb_cyc, wb_stb} <= 2'h0;
  endtask : wb_xfer

  task automatic send(input logic [192:0] w);
    spw_host_inst.send_word(w);
    check("serial out", serial_data_output, w[192]); // msb shows on serial out
  endtask : send

  // expected channel vector from the segment order (bit reversed index)
  function automatic logic [15:0] exp_on(input logic [11:0] g [16], input int slot);
    logic [4:0] seg;
    logic [4:0] rank;
    seg  = 5'(slot >> 7);
    rank = {<<{seg}};
    for (int c = 0; c < 16; c++)
      exp_on[c] = (slot % 128) < (g[c] >> 5) + (rank < g[c][4:0]);
    return exp_on;
  endfunction : exp_on

  function automatic logic [192:0] gs_word(input logic [11:0] g [16]);
    gs_word = '0;
    for (int c = 0; c < 16; c++)
      gs_word[12*c +: 12] = g[c];
  endfunction : gs_word

  function automatic logic [192:0] ctl_word(input logic [6:0] b, input logic [2:0] trb);
    ctl_word            = '0;
    ctl_word[192]       = 1'b1; // control destination
    ctl_word[118:112]   = b;
    ctl_word[122:119]   = {1'b1, trb};
  endfunction : ctl_word

  task automatic run_slots(input int n, input logic [11:0] ga [16], input logic [11:0] gb [16]);
    @(posedge grayscale_clock);
    for (int i = 0; i < n; i++)
    begin
      @(posedge grayscale_clock);
      check("channels", chan, i < 4096 ? exp_on(ga, i) : exp_on(gb, i % 4096));
    end
  endtask : run_slots

  initial
  begin
    repeat (90000) @(posedge mclk_i);
    n_fail++;
    stop_test();
  end

  initial
  begin
    {n_fail, n_checks, resetn_i, gs_en, wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_wdat} = '0;
    sel_req = 4'hf;
    gs1 = '{12'h020, 12'h021, 12'hfe0, 12'hfff, 12'h000, 12'h001, 12'h002, 12'h03f,
            12'h040, 12'h041, 12'hedf, 12'hfe1, 12'hffe, 12'h01f, 12'h003, 12'h800};
    foreach (gs1[c])
    begin
      gs2[c] = gs1[(c + 1) % 16];
      gs3[c] = gs1[15 - c];
    end
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    check("ctrl reset", rd, 32'h0000_0001);
    wb_xfer(1'b1, 8'h40, 32'hffff_ffff);
    wb_xfer(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    check("status reset", rd[17:0], 18'h2_0000); // blank, idle counter
    send(gs_word(gs1)); // loaded while blanked
    send(ctl_word(7'h55, 3'h2)); // repeat on, blank off
    check("brightness", bc, 7'h55);
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    check("function bits", rd[20:17], 4'ha);
    gs_en <= 1'b1;
    fork
      run_slots(4296, gs1, gs2); // one period, then 200 slots of the next
      begin
        repeat (600) @(posedge grayscale_clock);
        send(gs_word(gs2)); // held until period end
        wb_xfer(1'b0, 8'h04, 32'h0000_0000);
        check("counter kept", rd[11:0] > 12'h258, 1'b1);
      end
    join
    gs_en <= 1'b0;
    send(ctl_word(7'h2a, 3'h6));
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    check("timing reset bit", rd[19], 1'b1);
    check("brightness held", bc, 7'h55);
    send(gs_word(gs3));
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    check("counter cleared", rd[11:0], 12'h000);
    check("outputs forced off", chan, 16'h0000);
    check("brightness copied", bc, 7'h2a);
    gs_en <= 1'b1;
    run_slots(150, gs3, gs3); // new data from next tick
    gs_en <= 1'b0;
    // software gate: slot 150 stays shown while the grayscale clock stands
    wb_xfer(1'b1, 8'h00, 32'h0000_0000);
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    check("ctrl oe off", rd, 32'h0000_0000);
    check("channels gated", chan, 16'h0000);
    sel_req = 4'he;
    wb_xfer(1'b1, 8'h00, 32'h0000_0001);
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    check("ctrl sel masked", rd, 32'h0000_0000);
    sel_req = 4'hf;
    wb_xfer(1'b1, 8'h00, 32'h0000_0001);
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    check("ctrl oe on", rd, 32'h0000_0001);
    check("channels ungated", chan, exp_on(gs3, 150));
    send(ctl_word(7'h11, 3'h3));
    check("blank off", chan, 16'h0000);
    check("blank refresh", bc, 7'h11);
    stop_test();
  end
endmodule : tb
